// ### src/ddr_read_device.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
`include "ddr_read_defs.svh"

module ddr_read_device (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    output logic [15:0] dq,
    output logic dq_oe,
    output logic dqs,
    output logic dqs_n,
    output logic dqs_oe
);

    // Pin synchroniser: ck, cs_n, ras_n, cas_n, we_n, ba, addr
    logic [19:0] sync1;
    logic [19:0] sync2;
    logic ck_d;
    logic [19:0] pins;
    assign pins = {ck, cs_n, ras_n, cas_n, we_n, ba, addr};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 20'h00000;
            sync2 <= 20'h00000;
            ck_d <= 1'b0;
        end else if (ce) begin
            sync1 <= pins;
            sync2 <= sync1;
            ck_d <= sync2[19];
        end
    end

    logic link_rise;
    logic link_fall;
    logic [1:0] cmd_bank;
    logic [12:0] cmd_addr;
    ddr_read_pkg::cmd_t cmd;
    assign link_rise = sync2[19] & ~ck_d;
    assign link_fall = ~sync2[19] & ck_d;
    assign cmd_bank = sync2[14:13];
    assign cmd_addr = sync2[12:0];

    always_comb begin
        if (sync2[18]) begin
            cmd = ddr_read_pkg::CMD_NOP;
        end else begin
            unique case (sync2[17:15])
                3'b111: cmd = ddr_read_pkg::CMD_NOP;
                3'b011: cmd = ddr_read_pkg::CMD_ACTIVATE;
                3'b101: cmd = ddr_read_pkg::CMD_READ;
                3'b100: cmd = ddr_read_pkg::CMD_WRITE;
                3'b010: cmd = ddr_read_pkg::CMD_PRECHARGE;
                default: cmd = ddr_read_pkg::CMD_OTHER;
            endcase
        end
    end

    // Configuration held in the APB group, read here
    logic [31:0] config_reg;
    logic [2:0] cfg_al;
    logic [2:0] cfg_cl;
    logic cfg_bl8;
    logic [3:0] read_latency;
    logic [3:0] insert_idx;
    assign cfg_al = config_reg[`CFG_AL_LSB +: 3];
    assign cfg_cl = config_reg[`CFG_CL_LSB +: 3];
    assign cfg_bl8 = config_reg[`CFG_BL8_BIT];
    assign read_latency = {1'b0, cfg_al} + {1'b0, cfg_cl};
    // A latency below two leaves no room for the preamble, so it is clamped
    assign insert_idx = (read_latency < 4'h2) ? 4'h1 : read_latency - 4'h1;

    // Bank state, one slice per bank
    logic [3:0] bank_open;
    logic [3:0] bank_row [4];
    logic close_pulse;
    logic [1:0] close_bank;

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_bank
            logic next_open;
            logic [3:0] next_row;
            always_comb begin
                next_open = bank_open[b];
                next_row = bank_row[b];
                if (link_rise && cmd == ddr_read_pkg::CMD_ACTIVATE && cmd_bank == b) begin
                    next_open = 1'b1;
                    next_row = cmd_addr[3:0];
                end
                if (link_rise && cmd == ddr_read_pkg::CMD_PRECHARGE &&
                    (cmd_addr[`AUTO_PRE_BIT] || cmd_bank == b)) begin
                    next_open = 1'b0;
                end
                if (close_pulse && close_bank == b) begin
                    next_open = 1'b0;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bank_open[b] <= 1'b0;
                    bank_row[b] <= 4'h0;
                end else if (ce) begin
                    bank_open[b] <= next_open;
                    bank_row[b] <= next_row;
                end
            end
        end
    endgenerate

    // Read pipeline and burst output
    ddr_read_pkg::read_entry_t pipe [`PIPE_DEPTH];
    ddr_read_pkg::read_entry_t next_pipe [`PIPE_DEPTH];
    ddr_read_pkg::read_entry_t burst;
    ddr_read_pkg::read_entry_t next_burst;
    logic [3:0] remaining;
    logic [3:0] next_remaining;
    logic [2:0] elem;
    logic [2:0] next_elem;
    logic [15:0] read_count;
    logic [15:0] next_read_count;
    logic [15:0] next_dq;
    logic next_dq_oe;
    logic next_dqs;
    logic next_dqs_oe;
    logic next_close_pulse;
    logic [1:0] next_close_bank;
    logic [9:0] elem_col;
    ddr_read_pkg::read_entry_t new_entry;

    always_comb begin
        if (cfg_bl8) begin
            elem_col = {burst.col[9:3], burst.col[2:0] + elem};
        end else begin
            elem_col = {burst.col[9:2], burst.col[1:0] + elem[1:0]};
        end
        new_entry.valid = 1'b1;
        new_entry.auto_pre = cmd_addr[`AUTO_PRE_BIT];
        new_entry.bank = cmd_bank;
        new_entry.row = bank_row[cmd_bank];
        new_entry.col = cmd_addr[9:0];
    end

    always_comb begin
        next_pipe = pipe;
        next_burst = burst;
        next_remaining = remaining;
        next_elem = elem;
        next_read_count = read_count;
        next_dq = dq;
        next_dq_oe = dq_oe;
        next_dqs = dqs;
        next_dqs_oe = dqs_oe;
        next_close_pulse = 1'b0;
        next_close_bank = close_bank;
        if (link_rise) begin
            for (int i = 0; i < `PIPE_DEPTH - 1; i++) begin
                next_pipe[i] = pipe[i + 1];
            end
            next_pipe[`PIPE_DEPTH - 1] = '0;
            if (cmd == ddr_read_pkg::CMD_READ) begin
                next_pipe[insert_idx] = new_entry;
                next_read_count = read_count + 16'h0001;
            end
            if (pipe[0].valid) begin
                // A new burst replaces any running one: concatenation or truncation
                next_burst = pipe[0];
                next_remaining = (cfg_bl8 ? `BURST_EIGHT : `BURST_FOUR) - 4'h1;
                next_elem = 3'h1;
                next_dq = {pipe[0].bank, pipe[0].row, pipe[0].col};
                next_dq_oe = 1'b1;
                next_dqs = 1'b1;
                next_dqs_oe = 1'b1;
            end else if (remaining != 4'h0) begin
                next_remaining = remaining - 4'h1;
                next_elem = elem + 3'h1;
                next_dq = {burst.bank, burst.row, elem_col};
                next_dqs = 1'b1;
            end else if (pipe[1].valid) begin
                next_dq_oe = 1'b0;
                next_dqs = 1'b0;
                next_dqs_oe = 1'b1;
            end else begin
                next_dq_oe = 1'b0;
                next_dqs = 1'b0;
                next_dqs_oe = 1'b0;
            end
        end else if (link_fall && remaining != 4'h0) begin
            next_remaining = remaining - 4'h1;
            next_elem = elem + 3'h1;
            next_dq = {burst.bank, burst.row, elem_col};
            // Low with the last element doubles as the postamble
            next_dqs = 1'b0;
            if (remaining == 4'h1 && burst.auto_pre) begin
                next_close_pulse = 1'b1;
                next_close_bank = burst.bank;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `PIPE_DEPTH; i++) begin
                pipe[i] <= '0;
            end
            burst <= '0;
            remaining <= 4'h0;
            elem <= 3'h0;
            read_count <= 16'h0000;
            dq <= 16'h0000;
            dq_oe <= 1'b0;
            dqs <= 1'b0;
            dqs_n <= 1'b1;
            dqs_oe <= 1'b0;
            close_pulse <= 1'b0;
            close_bank <= 2'h0;
        end else if (ce) begin
            pipe <= next_pipe;
            burst <= next_burst;
            remaining <= next_remaining;
            elem <= next_elem;
            read_count <= next_read_count;
            dq <= next_dq;
            dq_oe <= next_dq_oe;
            dqs <= next_dqs;
            dqs_n <= ~next_dqs;
            dqs_oe <= next_dqs_oe;
            close_pulse <= next_close_pulse;
            close_bank <= next_close_bank;
        end
    end

    // APB slave: answer one cycle into the access phase
    logic access;
    logic mapped;
    logic [31:0] next_config;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    assign access = psel & penable & ~pready;
    assign mapped = (paddr == `ADDR_CONFIG) || (paddr == `ADDR_STATUS) ||
                    (paddr == `ADDR_READS);

    always_comb begin
        next_config = config_reg;
        next_prdata = prdata;
        next_pready = access;
        next_pslverr = access & ~mapped;
        if (access && !pwrite) begin
            unique case (paddr)
                `ADDR_CONFIG: next_prdata = config_reg;
                `ADDR_STATUS: next_prdata = {27'h0, remaining != 4'h0, bank_open};
                `ADDR_READS: next_prdata = {16'h0000, read_count};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        if (psel && penable && pready && pwrite && paddr == `ADDR_CONFIG) begin
            next_config = pwdata & `CFG_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= `CFG_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            config_reg <= next_config;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule : ddr_read_device

// ### inc/ddr_read_defs.svh
`ifndef DDR_READ_DEFS_SVH
`define DDR_READ_DEFS_SVH

`define ADDR_CONFIG 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_READS 12'h008

`define CFG_AL_LSB 0
`define CFG_CL_LSB 4
`define CFG_BL8_BIT 8
`define CFG_MASK 32'h0000_0177
`define CFG_RESET 32'h0000_0030

`define STATUS_BURST_BIT 4

`define PIPE_DEPTH 16
`define BURST_FOUR 4'h4
`define BURST_EIGHT 4'h8
`define AUTO_PRE_BIT 10

`endif

// ### inc/ddr_read_pkg.sv
package ddr_read_pkg;

    typedef enum logic [5:0] {
        CMD_NOP = 6'h01,
        CMD_ACTIVATE = 6'h02,
        CMD_READ = 6'h04,
        CMD_WRITE = 6'h08,
        CMD_PRECHARGE = 6'h10,
        CMD_OTHER = 6'h20
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic auto_pre;
        logic [1:0] bank;
        logic [3:0] row;
        logic [9:0] col;
    } read_entry_t;

endpackage : ddr_read_pkg

// ### tb/ddr_read_checker.sv
`timescale 1ns/1ns
module ddr_read_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] dq,
    input wire logic dq_oe,
    input wire logic dqs,
    input wire logic dqs_n,
    input wire logic dqs_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_pair; dqs_n == !dqs; endproperty
    a_pair: assert property (p_pair) else $error("strobe pair split");
    property p_strobe; dq_oe |-> dqs_oe; endproperty
    a_strobe: assert property (p_strobe) else $error("data without strobe");
    property p_pre; $rose(dqs_oe) |-> (!dqs && !dq_oe)[*8]; endproperty
    a_pre: assert property (p_pre) else $error("preamble too short");
    property p_first; $rose(dq_oe) |-> dqs; endproperty
    a_first: assert property (p_first) else $error("first element not on rise");
    // Sync lag jitters by one cycle, so a half ck period is nine cycles at least
    property p_hold; $changed(dq) && dq_oe |=> $stable(dq)[*7]; endproperty
    a_hold: assert property (p_hold) else $error("element too short");
    property p_post; $fell(dq_oe) |-> !$past(dqs); endproperty
    a_post: assert property (p_post) else $error("postamble not low");
    property p_rel; $fell(dqs_oe) |-> !dq_oe && !$past(dqs); endproperty
    a_rel: assert property (p_rel) else $error("bad release");
    property p_ready; psel && penable && !pready |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("apb answer late");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    c_pre: cover property ($rose(dqs_oe));
    c_end: cover property ($fell(dq_oe));
    c_err: cover property (pslverr);
endmodule : ddr_read_checker
bind ddr_read_device ddr_read_checker i_chk (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .dq, .dq_oe, .dqs, .dqs_n, .dqs_oe
);

// ### tb/ddr_ctrl_model.sv
`timescale 1ns/1ns
module ddr_ctrl_model (
    output logic ck,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [12:0] addr
);
    initial begin
        ck = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 2'h0;
        addr = 13'h0;
        // Odd offset keeps ck edges away from pclk edges
        #41;
        forever #40 ck = ~ck;
    end
    // Pins change on the falling edge so they are settled around the rise
    task drive(input logic [3:0] op, input logic [1:0] b, input logic [12:0] a);
        {cs_n, ras_n, cas_n, we_n} <= op;
        ba <= b;
        addr <= a;
        @(negedge ck);
        {cs_n, ras_n, cas_n, we_n} <= 4'hf;
        ba <= ~b;
        addr <= ~a;
    endtask : drive
endmodule : ddr_ctrl_model

// ### tb/sdram_row_activate_read_timing_test.sv
`timescale 1ns/1ns
`include "ddr_read_defs.svh"
module sdram_row_activate_read_timing_test;
    localparam logic [3:0] ACT = 4'h3;
    localparam logic [3:0] RD = 4'h5;
    localparam logic [3:0] PRE = 4'h2;
    localparam logic [3:0] WR = 4'h4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, ck, cs_n, ras_n, cas_n, we_n, dq_oe, dqs, dqs_n, dqs_oe, e;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [15:0] dq;
    logic [3:0] rows [4];
    logic [15:0] qv[$];
    int qe[$];
    int error_cnt, check_count, he, al, cl, bl, nrd, b, n, ap;
    int seed = 32'h2ca610aa;
    ddr_read_device i_dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .ck, .cs_n, .ras_n, .cas_n,
        .we_n, .ba, .addr, .dq, .dq_oe, .dqs, .dqs_n, .dqs_oe);
    ddr_ctrl_model i_ctrl (.ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);
    always #2 pclk = ~pclk;
    always @(ck) he <= he + 1;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        // Callers may return off the pclk grid, so the setup starts on an edge
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
        if (pready !== 1'b1) begin
            chk(pready, 1);
            tally_and_finish;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Queues the expected elements by ck edge index; a later start cuts the tail
    task cmd(input logic [3:0] op, input int bk, input logic [12:0] a);
        int k;
        int col;
        @(negedge ck);
        k = he + 1;
        col = a[9:0];
        if (op == ACT) rows[bk] = a[3:0];
        if (op == RD) begin
            nrd++;
            k = k + 2 * (al + cl < 2 ? 2 : al + cl);
            while (qe.size() > 0 && qe[$] >= k) begin
                void'(qe.pop_back());
                void'(qv.pop_back());
            end
            for (int i = 0; i < bl; i++) begin
                qe.push_back(k + i);
                qv.push_back({2'(bk), rows[bk], 10'((col & ~(bl - 1)) | ((col + i) & (bl - 1)))});
            end
        end
        i_ctrl.drive(op, 2'(bk), a);
    endtask : cmd
    always @(ck) begin
        int x;
        x = he;
        #30;
        if (qe.size() > 0 && qe[0] == x) begin
            // Strobe follows the level of ck after its edge; counting parity races at time 0
            chk({dq_oe, dqs, dq}, {1'b1, ck, qv[0]});
            void'(qe.pop_front());
            void'(qv.pop_front());
        end else if (presetn) begin
            chk(dq_oe, 0);
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADDR_CONFIG, 0);
        chk(r, `CFG_RESET);
        apb(1'b0, 12'h00c, 0);
        chk({e, r[30:0]}, 32'h8000_0000);
        apb(1'b1, `ADDR_CONFIG, 32'hffff_ffff);
        apb(1'b0, `ADDR_CONFIG, 0);
        chk(r, `CFG_MASK);
        repeat (10) begin
            al = $random(seed) & 3;
            cl = 2 + ($random(seed) & 3);
            bl = ($random(seed) & 1) ? 8 : 4;
            apb(1'b1, `ADDR_CONFIG, {bl == 8, 1'b0, 3'(cl), 1'b0, 3'(al)});
            b = $random(seed) & 3;
            ap = $random(seed) & 1;
            cmd(ACT, b, 13'($random(seed)));
            cmd(ACT, b ^ 1, 13'($random(seed)));
            cmd(RD, b, {3'h0, 10'($random(seed))});
            if (bl == 8 && ($random(seed) & 1)) repeat (2) @(negedge ck);
            cmd(RD, b, {2'h0, ap[0], 10'($random(seed))});
            for (n = 0; n < 300 && qe.size() > 0; n++) @(posedge ck);
            if (qe.size() > 0) begin
                chk(qe.size(), 0);
                tally_and_finish;
            end
            cmd(WR, b, 13'h0);
            repeat (2) @(negedge ck);
            apb(1'b0, `ADDR_STATUS, 0);
            chk(r, (ap ? 0 : 1 << b) | 1 << (b ^ 1));
            cmd(PRE, 0, 13'h400);
            repeat (2) @(negedge ck);
            apb(1'b0, `ADDR_STATUS, 0);
            chk(r, 0);
        end
        apb(1'b0, `ADDR_READS, 0);
        chk(r, nrd);
        tally_and_finish;
    end
endmodule : sdram_row_activate_read_timing_test
